// [spg_stack_guard.sv]
// Stack pointer guard unit: stack pointer, limit, stacking sequencer,
// overflow/underflow checks and the frame-active flag.
// Assumes execution holds op_valid_i only while busy_o is low and
// data memory answers a read in the same cycle as mem_re_o.
//
// Notes on behaviour
// R1: Stack pointer bit 0 always reads zero.
// R2: Any reset loads stack pointer with 0x1000.
// R3: Push writes then increments; pop decrements then reads.
// R4: Core may read and write pointer freely; code drops a core write while a stack access moves it.
// R5: Stack PC low word, then PC high bits.
// R6: Call high word upper byte is zero.
// R7: Exception high word carries status low byte.
// R8: Stack addresses never paged, 16 bits only.
// R9: Limit is 16 bits, bit 0 zero.
// R10: First word limit write arms checking permanently.
// R11: Push beyond limit by two traps.
// R12: Calls and interrupt stacking also trap.
// R13: Link with flag set, unlink clear, trap.
// R14: Armed checking traps on wrap past 0xFFFF.
// R15: Address below 0x1000 always traps.
// R16: Software avoids stack read right after limit write.
// R17: Flag at bit 2 confines frame pointer.
// R18: Link sets flag, unlink clears it.
// R19: Calls stack the flag, then clear it.
// R20: Returns restore flag from stacked word.
// R21: Data writes never change the flag.
// R22: Push and pop act as pointer moves.
// R23: Step is one word; trap is one-cycle pulse; code pulses each offending cycle, two for a call above the limit.
`timescale 1ns/1ps
`default_nettype none

module spg_stack_guard #(
  parameter int unsigned AW = 16 // Data address width
) (
  input  wire logic            clk_i,
  input  wire logic            nrst_i,
  // Operation request from instruction execution
  input  wire logic            op_valid_i,
  input  wire spg_pkg::spg_op_e op_i,
  input  wire logic [22:0]     pc_i,
  input  wire logic [7:0]      srl_i,
  input  wire logic [AW-1:0]   push_data_i,
  output logic                 busy_o,
  // Data memory port
  output logic [AW-1:0]        mem_addr_o,
  output logic [AW-1:0]        mem_wdata_o,
  output logic                 mem_we_o,
  output logic                 mem_re_o,
  input  wire logic [AW-1:0]   mem_rdata_i,
  // Pop and return results
  output logic [AW-1:0]        pop_data_o,
  output logic                 pop_valid_o,
  output logic [22:0]          ret_pc_o,
  output logic [7:0]           ret_srl_o,
  output logic                 ret_valid_o,
  // Stack pointer as a working register
  input  wire logic            sp_wr_i,
  input  wire logic [AW-1:0]   sp_wdata_i,
  output logic [AW-1:0]        sp_o,
  // Stack limit register
  input  wire logic            limit_wr_i,
  input  wire logic [1:0]      limit_be_i,
  input  wire logic [AW-1:0]   limit_wdata_i,
  output logic [AW-1:0]        limit_o,
  output logic                 check_en_o,
  // Other effective addresses formed from the stack pointer
  input  wire logic            ea_valid_i,
  input  wire logic            ea_push_i,
  input  wire logic [AW-1:0]   ea_i,
  // Frame pointer addressing
  input  wire logic [7:0]      fp_page_i,
  input  wire logic [AW-1:0]   fp_off_i,
  output logic [23:0]          fp_addr_o,
  output logic [15:0]          core_ctrl_o,
  // Stack error trap request
  output logic                 stack_err_o
);

  // Field split of the stacked words depends on a 16-bit path
  if (AW != 16) begin : g_aw_check
    $error("spg_stack_guard supports AW = 16 only");
  end

  spg_pkg::spg_state_e state;      // Sequencer state
  spg_pkg::spg_state_e next_state; // Following state
  logic [AW-1:0] sp;               // Stack pointer register
  logic [AW-1:0] limit;            // Stack limit register
  logic          chk_en;           // Overflow checking armed
  logic          is_exc;           // Current stacking is an exception
  logic          take;             // Request accepted this cycle
  logic          fa;               // Frame-active flag
  logic          fa_err;           // Link/unlink misuse
  logic          stacked;          // Second call word issued
  logic          restore;          // High return word arrives
  logic [AW-1:0] sp_dec;           // Pointer one word down
  logic [AW-1:0] sp_inc;           // Pointer one word up
  logic [AW-1:0] acc_addr;         // Address of access issued now
  logic          acc_valid;        // Access issued now
  logic          acc_push;         // Issued access is a write
  logic [AW-1:0] lim_next;         // Limit after byte lanes
  spg_chk_if #(.W(AW)) chk_seq (); // Sequencer accesses
  spg_chk_if #(.W(AW)) chk_ea ();  // Other pointer addresses

  // A request is only taken while idle
  assign busy_o = (state != spg_pkg::ST_IDLE);
  assign take   = op_valid_i && !busy_o;

  // Word steps; bit 0 stays zero since the step is even
  assign sp_inc = sp + spg_pkg::WORD_STEP; // R23
  assign sp_dec = sp - spg_pkg::WORD_STEP; // R23

  // Next state of the stacking sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      spg_pkg::ST_IDLE: begin
        if (take) begin
          unique case (op_i)
            spg_pkg::OP_CALL, spg_pkg::OP_IRQ: next_state = spg_pkg::ST_PUSH_HI;
            spg_pkg::OP_POP:                   next_state = spg_pkg::ST_POP_RD;
            spg_pkg::OP_RET, spg_pkg::OP_RETURN_LITERAL_INSTR, spg_pkg::OP_RETURN_FROM_INTERRUPT_INSTR: next_state = spg_pkg::ST_RET_HI;
            default:            next_state = spg_pkg::ST_IDLE;
          endcase
        end
      end
      spg_pkg::ST_PUSH_HI: next_state = spg_pkg::ST_IDLE;
      spg_pkg::ST_POP_RD:  next_state = spg_pkg::ST_IDLE;
      spg_pkg::ST_RET_HI:  next_state = spg_pkg::ST_RET_LO;
      spg_pkg::ST_RET_LO:  next_state = spg_pkg::ST_IDLE;
      default:             next_state = spg_pkg::ST_IDLE; // Illegal one-hot codes fall back to idle
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= spg_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Remember whether the stacking came from an exception
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      is_exc <= 1'b0;
    end else if (take) begin
      is_exc <= (op_i == spg_pkg::OP_IRQ);
    end
  end

  // Address of the access issued this cycle, for the checker.
  // Pushes use the pointer itself, pops the word below it.
  always_comb begin
    acc_valid = 1'b0;
    acc_push  = 1'b0;
    acc_addr  = sp;
    if (take) begin
      unique case (op_i)
        spg_pkg::OP_PUSH, spg_pkg::OP_CALL, spg_pkg::OP_IRQ: begin
          acc_valid = 1'b1; // R12
          acc_push  = 1'b1;
        end
        spg_pkg::OP_POP, spg_pkg::OP_RET, spg_pkg::OP_RETURN_LITERAL_INSTR, spg_pkg::OP_RETURN_FROM_INTERRUPT_INSTR: begin
          acc_valid = 1'b1;
          acc_addr  = sp_dec;
        end
        default: acc_valid = 1'b0;
      endcase
    end else if (state == spg_pkg::ST_PUSH_HI) begin
      acc_valid = 1'b1; // R12
      acc_push  = 1'b1;
    end else if (state == spg_pkg::ST_RET_HI) begin
      acc_valid = 1'b1;
      acc_addr  = sp_dec;
    end
  end

  // Stack pointer: automatic updates win over a core write, which
  // is only honoured when no stack access moves the pointer.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sp <= spg_pkg::SP_RESET; // R2
    end else if (acc_valid && acc_push) begin
      sp <= sp_inc; // R3 R22
    end else if (acc_valid) begin
      sp <= sp_dec; // R3 R22
    end else if (sp_wr_i) begin
      sp <= {sp_wdata_i[AW-1:1], 1'b0}; // R1 R4
    end
  end
  assign sp_o = sp; // R4

  // Memory request, registered; only 16-bit addresses exist
  always_ff @(posedge clk_i or negedge nrst_i) begin // R8
    if (!nrst_i) begin
      mem_addr_o  <= '0;
      mem_wdata_o <= '0;
      mem_we_o    <= 1'b0;
      mem_re_o    <= 1'b0;
    end else begin
      mem_we_o   <= acc_valid && acc_push;
      mem_re_o   <= acc_valid && !acc_push;
      mem_addr_o <= acc_addr;
      if (take && op_i == spg_pkg::OP_PUSH) begin
        mem_wdata_o <= push_data_i; // R22
      end else if (take) begin
        mem_wdata_o <= pc_i[AW-1:0]; // R5
      end else if (state == spg_pkg::ST_PUSH_HI && is_exc) begin
        mem_wdata_o <= {srl_i, pc_i[22:16], fa}; // R5 R7 R19
      end else if (state == spg_pkg::ST_PUSH_HI) begin
        mem_wdata_o <= {spg_pkg::CALL_HI_BYTE, pc_i[22:16], fa}; // R6 R19
      end
    end
  end

  // Results of pops and returns, captured from memory
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pop_data_o  <= '0;
      pop_valid_o <= 1'b0;
      ret_pc_o    <= '0;
      ret_srl_o   <= '0;
      ret_valid_o <= 1'b0;
    end else begin
      pop_valid_o <= (state == spg_pkg::ST_POP_RD);
      ret_valid_o <= (state == spg_pkg::ST_RET_LO);
      if (state == spg_pkg::ST_POP_RD) begin
        pop_data_o <= mem_rdata_i; // R22
      end
      if (state == spg_pkg::ST_RET_HI) begin
        ret_pc_o[22:16] <= mem_rdata_i[7:1];
        ret_srl_o       <= mem_rdata_i[15:8];
      end
      if (state == spg_pkg::ST_RET_LO) begin
        ret_pc_o[15:0] <= mem_rdata_i;
      end
    end
  end

  // Limit register: byte lanes update, bit 0 held at zero
  always_comb begin
    lim_next = limit;
    if (limit_be_i[0]) begin
      lim_next[7:0] = limit_wdata_i[7:0];
    end
    if (limit_be_i[1]) begin
      lim_next[15:8] = limit_wdata_i[15:8];
    end
    lim_next[0] = 1'b0; // R9
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      limit <= spg_pkg::LIMIT_RESET;
    end else if (limit_wr_i) begin
      limit <= lim_next; // R9
    end
  end
  assign limit_o = limit;

  // Checking arms on a word write only and stays armed until reset;
  // a byte write alone leaves it off.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chk_en <= 1'b0;
    end else if (limit_wr_i && (limit_be_i == 2'b11)) begin
      chk_en <= 1'b1; // R10
    end
  end
  assign check_en_o = chk_en;

  // Checker for accesses issued by the sequencer
  assign chk_seq.valid = acc_valid;
  assign chk_seq.push  = acc_push;
  assign chk_seq.addr  = acc_addr;
  assign chk_seq.limit = limit;
  assign chk_seq.en    = chk_en;

  spg_bound_chk #(.W(AW)) u_chk_seq (.c(chk_seq));

  // Checker for other pointer-based addresses formed by execution
  assign chk_ea.valid = ea_valid_i; // R11
  assign chk_ea.push  = ea_push_i;
  assign chk_ea.addr  = ea_i;
  assign chk_ea.limit = limit;
  assign chk_ea.en    = chk_en;

  spg_bound_chk #(.W(AW)) u_chk_ea (.c(chk_ea));

  // Frame flag control strobes
  assign stacked = (state == spg_pkg::ST_PUSH_HI);
  assign restore = (state == spg_pkg::ST_RET_HI);

  spg_frame_flag u_frame (
    .clk_i         (clk_i),
    .nrst_i        (nrst_i),
    .link_i        (take && op_i == spg_pkg::OP_LNK),
    .unlink_i      (take && op_i == spg_pkg::OP_FRAME_UNLINK_INSTR),
    .stacked_i     (stacked), // R19
    .restore_i     (restore), // R20
    .restore_val_i (mem_rdata_i[0]),
    .flag_o        (fa),
    .err_o         (fa_err)
  );

  // Frame pointer: paged when the flag is clear, base space when set
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fp_addr_o <= '0;
    end else if (fa) begin
      fp_addr_o <= {8'h00, fp_off_i}; // R17
    end else begin
      fp_addr_o <= {fp_page_i, fp_off_i};
    end
  end

  // Only the flag of the core control register lives here
  always_comb begin
    core_ctrl_o = '0;
    core_ctrl_o[spg_pkg::FA_BIT] = fa; // R17
  end

  // Trap request: one registered pulse per offending cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stack_err_o <= 1'b0;
    end else begin
      stack_err_o <= chk_seq.err || chk_ea.err || fa_err; // R23
    end
  end

endmodule

`default_nettype wire

// [spg_pkg.sv]
// Shared constants and types for the stack pointer guard unit.
// Assumes a 16-bit data path and a 23-bit program counter.
`default_nettype none

package spg_pkg;

  // Stack pointer reset value, also the lowest legal stack address
  localparam logic [15:0] SP_RESET    = 16'h1000;
  localparam logic [15:0] STACK_BASE  = 16'h1000;
  // One stack word is two byte addresses
  localparam logic [15:0] WORD_STEP   = 16'h0002;
  // Limit register value after reset; checking is off until a word write
  localparam logic [15:0] LIMIT_RESET = 16'h0000;
  // Last word below the top of data space; a push here wraps
  localparam logic [15:0] TOP_WORD    = 16'hFFFE;
  // Frame-active flag position in the core control register
  localparam int unsigned FA_BIT      = 2;
  // Upper byte of the second stacked word for calls
  localparam logic [7:0]  CALL_HI_BYTE = 8'h00;
  // Program counter width and the split between stacked words
  localparam int unsigned PC_W        = 23;
  localparam int unsigned PC_LO_W     = 16;

  // Operation codes issued by instruction execution
  typedef enum logic [3:0] {
    OP_PUSH   = 4'h0,
    OP_POP    = 4'h1,
    OP_CALL   = 4'h2,
    OP_IRQ    = 4'h3,
    OP_RET    = 4'h4,
    OP_RETURN_LITERAL_INSTR  = 4'h5,
    OP_RETURN_FROM_INTERRUPT_INSTR = 4'h6,
    OP_LNK    = 4'h7,
    OP_FRAME_UNLINK_INSTR   = 4'h8
  } spg_op_e;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_PUSH_HI = 5'b00010,
    ST_POP_RD = 5'b00100,
    ST_RET_HI = 5'b01000,
    ST_RET_LO = 5'b10000
  } spg_state_e;

endpackage

`default_nettype wire

// [spg_chk_if.sv]
// Carrier between one address source and one address bound checker.
// Assumes one clock; all members are plain levels.
`timescale 1ns/1ps
`default_nettype none

interface spg_chk_if #(
  parameter int unsigned W = 16
);
  logic         valid; // Address is being used this cycle
  logic         push;  // Access grows the stack
  logic [W-1:0] addr;  // Effective address from the stack pointer
  logic [W-1:0] limit; // Current stack limit
  logic         en;    // Overflow checking armed
  logic         err;   // Stack error seen on this address

  modport req (output valid, push, addr, limit, en, input err);
  modport chk (input valid, push, addr, limit, en, output err);
endinterface

`default_nettype wire

// [spg_bound_chk.sv]
// Combinational bound checker for one stack effective address.
// Assumes addresses are even; one instance per address source.
`timescale 1ns/1ps
`default_nettype none

module spg_bound_chk #(
  parameter int unsigned W = 16
) (
  spg_chk_if.chk c
);

  // The compare constants are 16 bits wide
  if (W != 16) begin : g_w_check
    $error("spg_bound_chk supports W = 16 only");
  end

  logic under; // Below the stack base
  logic over;  // Beyond limit by two or more
  logic wrap;  // Increment would pass the top of data space

  // Underflow holds whether or not checking is armed
  assign under = (c.addr < spg_pkg::STACK_BASE); // R15
  // Pointer above the limit means it exceeds it by a whole word
  assign over  = c.en && c.push && (c.addr > c.limit); // R11 R12
  assign wrap  = c.en && c.push && (c.addr == spg_pkg::TOP_WORD); // R14
  assign c.err = c.valid && (under || over || wrap);

endmodule

`default_nettype wire

// [spg_frame_flag.sv]
// Frame-active flag: set by link, cleared by unlink or call stacking.
// Assumes at most one of set, clear and restore per cycle.
`timescale 1ns/1ps
`default_nettype none

module spg_frame_flag (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic link_i,    // Frame link executes
  input  wire logic unlink_i,  // Frame unlink executes
  input  wire logic stacked_i, // Call or interrupt stacking done
  input  wire logic restore_i, // Return reloads the flag
  input  wire logic restore_val_i,
  output logic      flag_o,
  output logic      err_o      // Misuse of link or unlink
);

  // No data write path exists, so software cannot alter the flag
  always_ff @(posedge clk_i or negedge nrst_i) begin // R21
    if (!nrst_i) begin
      flag_o <= 1'b0;
    end else if (restore_i) begin
      flag_o <= restore_val_i; // R20
    end else if (link_i) begin
      flag_o <= 1'b1; // R18
    end else if (unlink_i || stacked_i) begin
      flag_o <= 1'b0; // R18 R19
    end
  end

  // Link on an active frame or unlink on none is an error
  assign err_o = (link_i && flag_o) || (unlink_i && !flag_o); // R13

endmodule

`default_nettype wire

// [spg_mem_model.sv]
// Data memory model standing beside the stack guard.
// Assumes reads answer in the same cycle as the read strobe.
`timescale 1ns/1ps
`default_nettype none

module spg_mem_model (
  input  wire logic        clk_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  output logic      [15:0] rdata_o
);
  logic [15:0] mem [0:65535]; // Flat base space, never paged
  logic [15:0] last;          // Last word handed out

  // Writes land at the edge; the last read is kept for idle scrambling
  always_ff @(posedge clk_i) begin
    if (we_i) mem[addr_i] <= wdata_i;
    if (re_i) last <= mem[addr_i];
  end

  // Idle bus shows the inverse so a stale value never passes as good
  assign rdata_o = re_i ? mem[addr_i] : ~last;
endmodule

`default_nettype wire

// [spg_stack_chk.sv]
// Concurrent checks on the stack guard ports.
// Assumes one clock domain; bound to every spg_stack_guard.
`timescale 1ns/1ps
`default_nettype none

module spg_stack_chk (
  input wire logic             clk_i,
  input wire logic             nrst_i,
  input wire logic             op_valid_i,
  input wire spg_pkg::spg_op_e op_i,
  input wire logic [22:0]      pc_i,
  input wire logic [7:0]       srl_i,
  input wire logic             busy_o,
  input wire logic [15:0]      mem_addr_o,
  input wire logic [15:0]      mem_wdata_o,
  input wire logic             mem_we_o,
  input wire logic             mem_re_o,
  input wire logic             pop_valid_o,
  input wire logic [15:0]      sp_o,
  input wire logic             limit_wr_i,
  input wire logic [1:0]       limit_be_i,
  input wire logic [15:0]      limit_wdata_i,
  input wire logic [15:0]      limit_o,
  input wire logic             check_en_o,
  input wire logic             ea_valid_i,
  input wire logic [15:0]      ea_i,
  input wire logic [23:0]      fp_addr_o,
  input wire logic [15:0]      core_ctrl_o,
  input wire logic             stack_err_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  wire take = op_valid_i && !busy_o; // Request accepted this edge

  a_word_align: assert property (sp_o[0] == 1'b0 && limit_o[0] == 1'b0)
    else $error("stack pointer or limit not word aligned");
  a_push_step: assert property (take && op_i == spg_pkg::OP_PUSH |=> mem_we_o && mem_addr_o == $past(sp_o)
    && sp_o == $past(sp_o) + 16'h0002) else $error("push not write then increment");
  a_pop_read: assert property (take && op_i == spg_pkg::OP_POP |=> mem_re_o
    && mem_addr_o == $past(sp_o) - 16'h0002 ##1 pop_valid_o) else $error("pop not decrement then read");
  a_call_words: assert property (take && op_i == spg_pkg::OP_CALL |=> mem_we_o && mem_wdata_o == 16'($past(pc_i))
    ##1 mem_we_o && mem_wdata_o[15:8] == 8'h00 && mem_wdata_o[7:1] == pc_i[22:16]) else $error("call words wrong");
  a_irq_status: assert property (take && op_i == spg_pkg::OP_IRQ |=> ##1 mem_we_o
    && mem_wdata_o[15:8] == $past(srl_i)) else $error("status byte not stacked");
  a_link_misuse: assert property (take && ((op_i == spg_pkg::OP_LNK && core_ctrl_o[2])
    || (op_i == spg_pkg::OP_FRAME_UNLINK_INSTR && !core_ctrl_o[2])) |=> stack_err_o) else $error("frame misuse not trapped");
  a_arm_sticky: assert property (check_en_o |=> check_en_o)
    else $error("checking dropped without reset");
  a_arm_word: assert property (limit_wr_i && limit_be_i == 2'b11 |=> check_en_o
    && limit_o == ($past(limit_wdata_i) & 16'hFFFE)) else $error("word limit write not taken");
  a_over_trap: assert property (take && check_en_o && sp_o > limit_o && (op_i == spg_pkg::OP_PUSH
    || op_i == spg_pkg::OP_CALL || op_i == spg_pkg::OP_IRQ) |-> ##[1:2] stack_err_o) else $error("overflow missed");
  a_under_trap: assert property (ea_valid_i && ea_i < 16'h1000 |=> stack_err_o)
    else $error("underflow missed");
  a_fp_unpaged: assert property (core_ctrl_o[2] && $past(core_ctrl_o[2]) |-> fp_addr_o[23:16] == 8'h00)
    else $error("frame pointer paged while frame active");

  c_call: cover property (take && op_i == spg_pkg::OP_CALL);
  c_trap: cover property (stack_err_o);
  c_arm: cover property ($rose(check_en_o));
endmodule

bind spg_stack_guard spg_stack_chk u_chk (.clk_i, .nrst_i, .op_valid_i, .op_i, .pc_i, .srl_i, .busy_o,
  .mem_addr_o, .mem_wdata_o, .mem_we_o, .mem_re_o, .pop_valid_o, .sp_o, .limit_wr_i, .limit_be_i,
  .limit_wdata_i, .limit_o, .check_en_o, .ea_valid_i, .ea_i, .fp_addr_o, .core_ctrl_o, .stack_err_o);

`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the stack guard with a data memory model.
// Assumes the stacking and return cycle counts given in the hand-over.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  typedef struct packed {
    spg_pkg::spg_op_e op;  // Operation
    logic [22:0]      arg; // Program counter or push data
    logic [7:0]       status_low_byte; // Status byte in, or expected back
    logic [15:0]      sp;  // Stack pointer afterwards
    logic             fa;  // Frame flag afterwards
    logic [22:0]      val; // Stacked word, popped data or return PC
  } spg_row_s;

  logic             clk_i = 1'b0, nrst_i = 1'b0, op_valid_i = 1'b0;
  spg_pkg::spg_op_e op_i = spg_pkg::OP_PUSH;
  logic [22:0]      pc_i = 23'h0;
  logic [7:0]       srl_i = 8'h00, fp_page_i = 8'h5A; // Page is nonzero to expose paging
  logic [15:0]      push_data_i = 16'h0, sp_wdata_i = 16'h0, limit_wdata_i = 16'h0, ea_i = 16'h2000;
  logic             sp_wr_i = 1'b0, limit_wr_i = 1'b0, ea_valid_i = 1'b0, ea_push_i = 1'b0;
  logic [1:0]       limit_be_i = 2'b00;
  logic [15:0]      fp_off_i = 16'h0123;
  logic             busy_o, mem_we_o, mem_re_o, pop_valid_o, ret_valid_o, check_en_o, stack_err_o;
  logic [15:0]      mem_addr_o, mem_wdata_o, mem_rdata_i, pop_data_o, sp_o, limit_o, core_ctrl_o;
  logic [22:0]      ret_pc_o;
  logic [7:0]       ret_srl_o;
  logic [23:0]      fp_addr_o;
  int               n_fail = 0, checks_done = 0, n_trap = 0, n_ret = 0, n_busy = 0;

  // Ordinary operations: stack grows up from the reset base
  spg_row_s rows [11] = '{
    '{spg_pkg::OP_PUSH,   23'h005A5A, 8'h00, 16'h1002, 1'b0, 23'h005A5A},
    '{spg_pkg::OP_PUSH,   23'h003636, 8'h00, 16'h1004, 1'b0, 23'h003636},
    '{spg_pkg::OP_POP,    23'h000000, 8'h00, 16'h1002, 1'b0, 23'h003636},
    '{spg_pkg::OP_LNK,    23'h000000, 8'h00, 16'h1002, 1'b1, 23'h000000},
    '{spg_pkg::OP_CALL,   23'h7ABCDE, 8'h00, 16'h1006, 1'b0, 23'h0000F5},
    '{spg_pkg::OP_RET,    23'h000000, 8'h00, 16'h1002, 1'b1, 23'h7ABCDE},
    '{spg_pkg::OP_FRAME_UNLINK_INSTR,   23'h000000, 8'h00, 16'h1002, 1'b0, 23'h000000},
    '{spg_pkg::OP_IRQ,    23'h012345, 8'hA5, 16'h1006, 1'b0, 23'h00A502},
    '{spg_pkg::OP_RETURN_FROM_INTERRUPT_INSTR, 23'h000000, 8'hA5, 16'h1002, 1'b0, 23'h012345},
    '{spg_pkg::OP_CALL,   23'h000010, 8'h00, 16'h1006, 1'b0, 23'h000000},
    '{spg_pkg::OP_RETURN_LITERAL_INSTR,  23'h000000, 8'h00, 16'h1002, 1'b0, 23'h000010}};

  spg_stack_guard uut (.clk_i, .nrst_i, .op_valid_i, .op_i, .pc_i, .srl_i, .push_data_i, .busy_o,
    .mem_addr_o, .mem_wdata_o, .mem_we_o, .mem_re_o, .mem_rdata_i, .pop_data_o, .pop_valid_o, .ret_pc_o,
    .ret_srl_o, .ret_valid_o, .sp_wr_i, .sp_wdata_i, .sp_o, .limit_wr_i, .limit_be_i, .limit_wdata_i,
    .limit_o, .check_en_o, .ea_valid_i, .ea_push_i, .ea_i, .fp_page_i, .fp_off_i, .fp_addr_o,
    .core_ctrl_o, .stack_err_o);

  spg_mem_model u_mem (.clk_i(clk_i), .we_i(mem_we_o), .re_i(mem_re_o), .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

  // 200 MHz core clock
  always #2.5 clk_i = ~clk_i;

  // Pulses and busy cycles are counted mid-cycle, clear of the edge that launches them
  always @(negedge clk_i) if (stack_err_o === 1'b1) n_trap++;
  always @(negedge clk_i) if (ret_valid_o === 1'b1) n_ret++;
  always @(negedge clk_i) if (busy_o === 1'b1) n_busy++;

  task automatic chk(input logic [22:0] got, input logic [22:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One request, then enough cycles for the longest answer
  task automatic run_op(input spg_pkg::spg_op_e op, input logic [22:0] arg, input logic [7:0] status_low_byte);
    @(negedge clk_i);
    op_valid_i = 1'b1;
    op_i = op;
    pc_i = arg;
    push_data_i = arg[15:0];
    srl_i = status_low_byte;
    @(negedge clk_i);
    op_valid_i = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask

  // Core write of the pointer or the limit; the next stack access is never a read
  task automatic wr_reg(input logic lim, input logic [1:0] be, input logic [15:0] d);
    @(negedge clk_i);
    sp_wr_i = !lim;
    limit_wr_i = lim;
    limit_be_i = be;
    sp_wdata_i = d;
    limit_wdata_i = d;
    @(negedge clk_i);
    sp_wr_i = 1'b0;
    limit_wr_i = 1'b0;
    @(negedge clk_i);
  endtask

  // Other pointer-based address offered for checking
  task automatic ea_chk(input logic [15:0] a, input logic p);
    @(negedge clk_i);
    ea_valid_i = 1'b1;
    ea_push_i = p;
    ea_i = a;
    @(negedge clk_i);
    ea_valid_i = 1'b0;
    @(negedge clk_i);
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard, far beyond the roughly 160 cycles the run needs
  initial begin
    #20000;
    n_fail++;
    summarize();
  end

  initial begin
    spg_row_s r;
    int       t0;
    repeat (5) @(negedge clk_i);
    nrst_i = 1'b1;
    chk(sp_o, 23'h1000);
    foreach (rows[i]) begin
      r = rows[i];
      run_op(r.op, r.arg, r.status_low_byte);
      chk(sp_o, 23'(r.sp));
      chk(core_ctrl_o, {r.fa, 2'b00});
      chk(23'(fp_addr_o[23:16]), r.fa ? 23'h0 : 23'h5A);
      case (r.op)
        spg_pkg::OP_PUSH: chk(u_mem.mem[r.sp - 16'h0002], r.val);
        spg_pkg::OP_POP: chk(pop_data_o, r.val);
        spg_pkg::OP_CALL, spg_pkg::OP_IRQ: begin
          chk(u_mem.mem[r.sp - 16'h0002], r.val);
          chk(u_mem.mem[r.sp - 16'h0004], 23'(r.arg[15:0]));
        end
        spg_pkg::OP_RET, spg_pkg::OP_RETURN_LITERAL_INSTR, spg_pkg::OP_RETURN_FROM_INTERRUPT_INSTR: begin
          chk(ret_pc_o, r.val);
          chk(ret_srl_o, r.status_low_byte);
        end
        default: ;
      endcase
    end
    chk(23'(n_trap), 23'h0);
    chk(23'(n_ret), 23'h3);
    chk(23'(n_busy), 23'hA);
    // Second pop goes below the base; a low side address also traps
    t0 = n_trap;
    run_op(spg_pkg::OP_POP, 23'h0, 8'h00);
    run_op(spg_pkg::OP_POP, 23'h0, 8'h00);
    ea_chk(16'h0800, 1'b0);
    chk(23'(n_trap - t0), 23'h2);
    // Unlink while clear, then link twice
    run_op(spg_pkg::OP_FRAME_UNLINK_INSTR, 23'h0, 8'h00);
    run_op(spg_pkg::OP_LNK, 23'h0, 8'h00);
    run_op(spg_pkg::OP_LNK, 23'h0, 8'h00);
    chk(23'(n_trap - t0), 23'h4);
    wr_reg(1'b0, 2'b11, 16'h1007);
    chk(sp_o, 23'h1006);
    chk(core_ctrl_o, 23'h4);
    run_op(spg_pkg::OP_FRAME_UNLINK_INSTR, 23'h0, 8'h00);
    // A byte write must not arm checking, so a wrap stays quiet
    wr_reg(1'b1, 2'b01, 16'h1005);
    chk(check_en_o, 1'b0);
    ea_chk(16'hFFFE, 1'b1);
    chk(23'(n_trap - t0), 23'h4);
    wr_reg(1'b1, 2'b11, 16'h1005);
    chk(limit_o, 23'h1004);
    chk(check_en_o, 1'b1);
    // Push at the limit is legal, the next one is not
    wr_reg(1'b0, 2'b11, 16'h1004);
    run_op(spg_pkg::OP_PUSH, 23'h1111, 8'h00);
    chk(23'(n_trap - t0), 23'h4);
    run_op(spg_pkg::OP_PUSH, 23'h2222, 8'h00);
    chk(23'(n_trap - t0), 23'h5);
    t0 = n_trap;
    run_op(spg_pkg::OP_CALL, 23'h001234, 8'h00);
    chk(23'(n_trap != t0), 23'h1);
    // Limit at the top, so only the wrap itself can trap
    wr_reg(1'b1, 2'b11, 16'hFFFF);
    t0 = n_trap;
    ea_chk(16'hFFFE, 1'b1);
    chk(23'(n_trap - t0), 23'h1);
    // Reset in mid-run restores the base and disarms checking
    @(negedge clk_i);
    nrst_i = 1'b0;
    @(negedge clk_i);
    chk(sp_o, 23'h1000);
    chk(check_en_o, 1'b0);
    nrst_i = 1'b1;
    // First request after release grows from the base again
    run_op(spg_pkg::OP_PUSH, 23'h4444, 8'h00);
    chk(sp_o, 23'h1002);
    chk(u_mem.mem[16'h1000], 23'h4444);
    summarize();
  end
endmodule

`default_nettype wire
